// ### inc/psc_consts.svh
// Purpose: timing and size constants of the passive-serial configuration link
// Assumes: core clock of 50 MHz
// Notes: times keep their printed unit; cycle counts are derived below
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

`define PSC_CLK_NS 20
// device response limits (ns)
`define PSC_T_CF2CD_NS 600
`define PSC_T_CF2ST0_NS 600
// request and status widths, and delays from request or status to status and first clock (us)
`define PSC_T_CFG_US 2
`define PSC_T_STATUS_MIN_US 268
`define PSC_T_STATUS_MAX_US 1506
`define PSC_T_CF2ST1_US 1506
`define PSC_T_CF2CK_US 1506
`define PSC_T_ST2CK_US 2
// user-mode entry window with the internal oscillator (us)
`define PSC_T_CD2UM_MIN_US 175
`define PSC_T_CD2UM_MAX_US 437
// fastest config clock period (ns) and clock-enable delay in such periods
`define PSC_T_CONFIG_CLOCK_MIN_NS 8
`define PSC_CD2CU_PERIODS 4
`define PSC_T_INIT_CYCLES 17408
`define PSC_BITSTREAM_BITS 71015712
// high half period of the generated config clock in core cycles; the low half takes at least one more (180 ns period at best)
`define PSC_CONFIG_CLOCK_HALF 4

// derived counts: least times round up, longest times round down
`define PSC_CF2CD_CYC (`PSC_T_CF2CD_NS / `PSC_CLK_NS)
`define PSC_CFG_CYC ((`PSC_T_CFG_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_STATUS_MIN_CYC ((`PSC_T_STATUS_MIN_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_STATUS_MAX_CYC ((`PSC_T_STATUS_MAX_US * 1000) / `PSC_CLK_NS)
`define PSC_CF2CK_CYC ((`PSC_T_CF2CK_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_ST2CK_CYC ((`PSC_T_ST2CK_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_CD2UM_MIN_CYC ((`PSC_T_CD2UM_MIN_US * 1000 + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_CD2CU_CYC ((`PSC_CD2CU_PERIODS * `PSC_T_CONFIG_CLOCK_MIN_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)

`endif

// ### inc/psc_pkg.sv
// Purpose: types shared by both ends of the configuration link
// Assumes: nothing beyond the constants header
// Notes: state of the device and of the host is one packed struct each
package psc_pkg;

    typedef enum logic [1:0] {
        PSC_SRC_OSC,
        PSC_SRC_USER,
        PSC_SRC_CFG
    } psc_init_src_e;

    typedef enum logic [2:0] {
        DEV_CLEAR,
        DEV_LOAD,
        DEV_INIT,
        DEV_USER
    } psc_dev_state_e;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_REQ,
        HST_WAIT,
        HST_LOAD,
        HST_DONE
    } psc_hst_state_e;

    typedef struct packed {
        psc_dev_state_e st;
        logic [31:0] tmr;
        logic [31:0] cnt;
        logic config_clock_d;
        logic uclk_d;
        logic status_rel;
        logic done;
        logic user;
        logic bit_q;
        logic bit_stb;
    } psc_dev_s;

    typedef struct packed {
        psc_hst_state_e st;
        logic [31:0] tmr;
        logic [31:0] cnt;
        logic [7:0] div;
        logic have;
        logic ck;
        logic dat;
        logic req_n;
        logic rdy;
        logic busy;
        logic done;
        logic err;
    } psc_hst_s;

endpackage

// ### inc/psc_link_if.sv
// Purpose: pins between configuration host and device
// Assumes: status line is open-drain, pulled high when nobody drives it
// Notes: enables are active low; a driver only ever pulls low
`timescale 1ns/1ps
interface psc_link_if;
    logic config_req_n;
    logic config_clock;
    logic config_data;
    logic load_done;
    logic status_dev_o;
    logic status_dev_oe_n;
    logic status_host_o;
    logic status_host_oe_n;
    logic status_n;

    // wired-and of both drivers with a pull-up
    assign status_n = (!status_dev_oe_n && !status_dev_o) ? 1'b0 :
                      (!status_host_oe_n && !status_host_o) ? 1'b0 : 1'b1;

    modport device (
        input config_req_n, config_clock, config_data, status_n,
        output load_done, status_dev_o, status_dev_oe_n
    );

    modport host (
        input load_done, status_n,
        output config_req_n, config_clock, config_data, status_host_o, status_host_oe_n
    );
endinterface

// ### src/psc_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to core_clk
// Notes: a bit changes only once stages two and three agree
`timescale 1ns/1ps
module psc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] din,
    input wire logic [WIDTH-1:0] init_val,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } psc_sync_s;

    psc_sync_s r;
    psc_sync_s n;
    logic primed_r;

    // stage one feeds only stage two; the filter looks at two and three
    always_comb begin
        n = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
        // the later stages start from the idle level too, so no false edge follows reset
        if (!primed_r) begin
            n.s2 = init_val;
            n.s3 = init_val;
            n.q = init_val;
        end
    end

    // init value is caught by the clock after release, never by the reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            primed_r <= 1'b0;
        end else begin
            r <= n;
            primed_r <= 1'b1;
        end
    end

    assign dout = r.q;
endmodule

// ### src/psc_device.sv
// Purpose: device end of passive-serial configuration: reset, load, initialise
// Assumes: link pins arrive asynchronously and pass a three-flop filter
// Notes: long waits are parameters so that a simulation can shorten them
`timescale 1ns/1ps
`include "psc_consts.svh"

module psc_device #(
    parameter int unsigned STATUS_MIN_CYC = `PSC_STATUS_MIN_CYC,
    parameter int unsigned CD2UM_MIN_CYC = `PSC_CD2UM_MIN_CYC,
    parameter int unsigned T_INIT = `PSC_T_INIT_CYCLES,
    parameter int unsigned BITS = `PSC_BITSTREAM_BITS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    psc_link_if.device link,
    input wire logic user_init_clock,
    input wire psc_pkg::psc_init_src_e init_src,
    input wire logic user_clk_opt_en,
    output logic user_mode,
    output logic cfg_bit,
    output logic cfg_bit_stb
);
    import psc_pkg::*;

    localparam logic [31:0] CD2CU_CYC = 32'(`PSC_CD2CU_CYC);

    psc_dev_s r;
    psc_dev_s n;
    logic [4:0] pins;
    logic s_req_n;
    logic s_config_clock;
    logic s_data;
    logic s_status;
    logic s_uclk;
    logic config_clock_rise;
    logic uclk_rise;
    psc_init_src_e src_eff;

    // all link inputs, the user clock among them, come from another domain
    psc_sync #(
        .WIDTH(5)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .din({link.config_req_n, link.config_clock, link.config_data,
              link.status_n, user_init_clock}),
        .init_val(5'h10), // request idles high; clocks idle low like their edge flops
        .dout(pins)
    );

    assign s_req_n = pins[4];
    assign s_config_clock = pins[3];
    assign s_data = pins[2];
    assign s_status = pins[1];
    assign s_uclk = pins[0];
    assign config_clock_rise = s_config_clock && !r.config_clock_d;
    assign uclk_rise = s_uclk && !r.uclk_d;

    // the user clock is honoured only with its option on; else oscillator
    always_comb begin
        src_eff = init_src;
        if (init_src == PSC_SRC_USER && !user_clk_opt_en) begin
            src_eff = PSC_SRC_OSC;
        end
    end

    // sequencer: clear, load, initialise, user mode
    always_comb begin
        n = r;
        n.config_clock_d = s_config_clock;
        n.uclk_d = s_uclk;
        n.bit_stb = 1'b0;
        case (r.st)
            DEV_CLEAR: begin
                n.status_rel = 1'b0;
                n.done = 1'b0;
                n.user = 1'b0;
                if (r.tmr < 32'(STATUS_MIN_CYC)) begin
                    n.tmr = r.tmr + 32'h1;
                end
                // min width always kept; request high by then releases at once
                if (s_req_n && r.tmr >= 32'(STATUS_MIN_CYC)) begin
                    n.status_rel = 1'b1;
                    n.st = DEV_LOAD;
                    n.cnt = '0;
                end
            end
            DEV_LOAD: begin
                // bits are taken only while the status line is seen high
                if (config_clock_rise && s_status) begin
                    n.bit_q = s_data;
                    n.bit_stb = 1'b1;
                    n.cnt = r.cnt + 32'h1;
                    if (r.cnt == 32'(BITS) - 32'h1) begin
                        n.done = 1'b1;
                        n.st = DEV_INIT;
                        n.tmr = '0;
                        n.cnt = '0;
                    end
                end
            end
            DEV_INIT: begin
                n.tmr = r.tmr + 32'h1;
                case (src_eff)
                    PSC_SRC_OSC: begin
                        // fixed wait stands in for the oscillator's cycle count
                        if (r.tmr >= 32'(CD2UM_MIN_CYC) - 32'h1) begin
                            n.st = DEV_USER;
                        end
                    end
                    PSC_SRC_USER: begin
                        // edges before the enable delay are not counted
                        if (uclk_rise && r.tmr >= CD2CU_CYC) begin
                            n.cnt = r.cnt + 32'h1;
                        end
                        if (r.cnt >= 32'(T_INIT)) begin
                            n.st = DEV_USER;
                        end
                    end
                    PSC_SRC_CFG: begin
                        if (config_clock_rise) begin
                            n.cnt = r.cnt + 32'h1;
                        end
                        if (r.cnt >= 32'(T_INIT)) begin
                            n.st = DEV_USER;
                        end
                    end
                    default: begin
                        n.st = DEV_USER;
                    end
                endcase
            end
            DEV_USER: begin
                n.user = 1'b1;
            end
            default: begin
                n.st = DEV_CLEAR;
            end
        endcase
        // a low request overrides the state, status, done and user mode, and restarts the sequence
        if (!s_req_n) begin
            n.st = DEV_CLEAR;
            n.tmr = (r.st == DEV_CLEAR) ? n.tmr : 32'h0;
            n.status_rel = 1'b0;
            n.done = 1'b0;
            n.user = 1'b0;
        end
    end

    // power-up behaves like a request: status held low, nothing loaded
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{st: DEV_CLEAR, tmr: 32'h0, cnt: 32'h0, config_clock_d: 1'b0, uclk_d: 1'b0,
                   status_rel: 1'b0, done: 1'b0, user: 1'b0, bit_q: 1'b0, bit_stb: 1'b0};
        end else begin
            r <= n;
        end
    end

    // open-drain status: the same flop drives the level and the enable
    assign link.status_dev_o = r.status_rel;
    assign link.status_dev_oe_n = r.status_rel;
    assign link.load_done = r.done;
    assign user_mode = r.user;
    assign cfg_bit = r.bit_q;
    assign cfg_bit_stb = r.bit_stb;
endmodule

// ### src/psc_host.sv
// Purpose: host end of passive-serial configuration: request, wait, stream bits
// Assumes: the bit source holds bit_valid until bit_ready pulses
// Notes: the config clock is divided from core_clk and driven out
`timescale 1ns/1ps
`include "psc_consts.svh"
module psc_host #(
    parameter int unsigned CF2CK_CYC = `PSC_CF2CK_CYC,
    parameter int unsigned BITS = `PSC_BITSTREAM_BITS,
    parameter int unsigned CONFIG_CLOCK_HALF = `PSC_CONFIG_CLOCK_HALF
) (
    input wire logic core_clk,
    input wire logic reset_n,
    psc_link_if.host link,
    input wire logic start,
    input wire logic watch_status,
    input wire logic bit_data,
    input wire logic bit_valid,
    output logic bit_ready,
    output logic busy,
    output logic done,
    output logic error
);
    import psc_pkg::*;

    localparam logic [31:0] CFG_CYC = 32'(`PSC_CFG_CYC);
    localparam logic [31:0] ST2CK_CYC = 32'(`PSC_ST2CK_CYC);

    psc_hst_s r;
    psc_hst_s n;
    logic [1:0] pins;
    logic s_status;
    logic s_done;

    psc_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .din({link.status_n, link.load_done}),
        .init_val(2'h2),
        .dout(pins)
    );

    assign s_status = pins[1];
    assign s_done = pins[0];

    // request, first-clock wait, bit streaming, then wait for load-complete
    always_comb begin
        n = r;
        n.rdy = 1'b0;
        case (r.st)
            HST_IDLE: begin
                if (start) begin
                    n.st = HST_REQ;
                    n.req_n = 1'b0;
                    n.tmr = '0;
                    n.busy = 1'b1;
                    n.done = 1'b0;
                    n.err = 1'b0;
                end
            end
            HST_REQ: begin
                n.tmr = r.tmr + 32'h1;
                if (r.tmr >= CFG_CYC - 32'h1) begin
                    n.req_n = 1'b1;
                    n.tmr = '0;
                    n.st = HST_WAIT;
                end
            end
            HST_WAIT: begin
                n.tmr = r.tmr + 32'h1;
                if (watch_status) begin
                    // the wait restarts whenever status is seen low
                    if (!s_status) begin
                        n.tmr = '0;
                    end else if (r.tmr >= ST2CK_CYC - 32'h1) begin
                        n.st = HST_LOAD;
                    end
                end else if (r.tmr >= 32'(CF2CK_CYC) - 32'h1) begin
                    n.st = HST_LOAD;
                end
                n.cnt = '0;
                n.div = '0;
                n.have = 1'b0;
            end
            HST_LOAD: begin
                if (!r.ck && !r.have) begin
                    // an empty source stalls the clock low
                    if (bit_valid) begin
                        n.dat = bit_data;
                        n.have = 1'b1;
                        n.rdy = 1'b1;
                        n.div = '0;
                    end
                end else begin
                    n.div = r.div + 8'h1;
                    if (r.div == 8'(CONFIG_CLOCK_HALF) - 8'h1) begin
                        n.div = '0;
                        n.ck = !r.ck;
                        if (r.ck) begin
                            n.have = 1'b0;
                            n.cnt = r.cnt + 32'h1;
                            if (r.cnt == 32'(BITS) - 32'h1) begin
                                n.st = HST_DONE;
                            end
                        end
                    end
                end
                // status low while loading is an error: restart from the request
                if (!s_status) begin
                    n.err = 1'b1;
                    n.st = HST_REQ;
                    n.req_n = 1'b0;
                    n.tmr = '0;
                    n.ck = 1'b0;
                    n.have = 1'b0;
                end
            end
            HST_DONE: begin
                if (s_done) begin
                    n.done = 1'b1;
                    n.busy = 1'b0;
                    n.st = HST_IDLE;
                end
            end
            default: begin
                n.st = HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{st: HST_IDLE, tmr: 32'h0, cnt: 32'h0, div: 8'h0, have: 1'b0, ck: 1'b0,
                   dat: 1'b0, req_n: 1'b1, rdy: 1'b0, busy: 1'b0, done: 1'b0, err: 1'b0};
        end else begin
            r <= n;
        end
    end

    // host never pulls status; its driver stays released
    assign link.status_host_o = 1'b1;
    assign link.status_host_oe_n = 1'b1;
    assign link.config_req_n = r.req_n;
    assign link.config_clock = r.ck;
    assign link.config_data = r.dat;
    assign bit_ready = r.rdy;
    assign busy = r.busy;
    assign done = r.done;
    assign error = r.err;
endmodule

// ### verif/psc_checker.sv
// Purpose: concurrent checks on the pins between configuration host and device
// Assumes: sampled on core_clk; reset_n active low; counts are 20 ns core cycles
// Notes: limits follow the shortened parameters handed in by the bench
`timescale 1ns/1ps
`include "psc_consts.svh"
module psc_checker #(
    parameter int STATUS_MIN = 20,
    parameter int BITS = 32,
    parameter int CF2CK = 50
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic config_req_n,
    input wire logic config_clock,
    input wire logic config_data,
    input wire logic load_done,
    input wire logic status_n
);
    localparam int MIN_2US = `PSC_CFG_CYC;
    localparam int REL_MAX = STATUS_MIN + 12;
    logic [31:0] req_lo_r, req_hi_r, st_lo_r, st_hi_r, rises_r;
    logic clk_d_r, first_r;

    // run lengths of each request and status level, and clock rises since the last request
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_lo_r <= 32'h0;
            req_hi_r <= 32'h0;
            st_lo_r <= 32'h0;
            st_hi_r <= 32'h0;
            rises_r <= 32'h0;
            clk_d_r <= 1'b0;
            first_r <= 1'b0;
        end else begin
            req_lo_r <= config_req_n ? 32'h0 : req_lo_r + 32'h1;
            req_hi_r <= config_req_n ? req_hi_r + 32'h1 : 32'h0;
            st_lo_r <= status_n ? 32'h0 : st_lo_r + 32'h1;
            st_hi_r <= status_n ? st_hi_r + 32'h1 : 32'h0;
            clk_d_r <= config_clock;
            if (!config_req_n) begin
                rises_r <= 32'h0;
                first_r <= 1'b1;
            end else if (config_clock && !clk_d_r) begin
                rises_r <= rises_r + 32'h1;
                first_r <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    cd_low_fast_a: assert property ($fell(config_req_n) |-> ##[1:30] !load_done)
        else $error("load_done not low within 600 ns of request");
    st_low_fast_a: assert property ($fell(config_req_n) |-> ##[1:30] !status_n)
        else $error("status not low within 600 ns of request");
    req_width_a: assert property ($rose(config_req_n) |-> req_lo_r >= 32'(MIN_2US))
        else $error("request low pulse too short");
    st_min_a: assert property ($rose(status_n) |-> st_lo_r >= 32'(STATUS_MIN - 1))
        else $error("status low pulse too short");
    st_release_a: assert property ($rose(config_req_n) |-> ##[0:REL_MAX] status_n)
        else $error("status not released after request");
    first_clk_a: assert property ($rose(config_clock) && first_r |->
        (st_hi_r >= 32'(MIN_2US) || req_hi_r >= 32'(CF2CK - 1)))
        else $error("first config clock rise too early");
    clk_idle_a: assert property (!config_req_n |-> !config_clock)
        else $error("config clock runs during request");
    bit_count_a: assert property ($rose(load_done) |-> rises_r == 32'(BITS))
        else $error("load complete after wrong bit count");
    clk_high_a: assert property ($rose(config_clock) |-> config_clock [*4])
        else $error("config clock high phase too short");
    clk_low_a: assert property ($fell(config_clock) |-> !config_clock [*4])
        else $error("config clock low phase too short");
    data_setup_a: assert property ($rose(config_clock) |-> $stable(config_data))
        else $error("config data changed at clock rise");

    cover property ($rose(load_done));
    cover property ($rose(config_clock) && first_r && st_hi_r >= 32'(MIN_2US));
    cover property ($rose(config_clock) && first_r && st_hi_r < 32'(MIN_2US));
endmodule

// ### verif/tb_passive_serial_config_sequence.sv
// Purpose: self-checking bench joining host and device ends over one link
// Assumes: inputs change at the falling edge; counts shortened by parameters
// Notes: a queue of taken bits models the stream; device reset pokes a load error
`timescale 1ns/1ps
module tb_passive_serial_config_sequence;
    import psc_pkg::*;
    localparam int BITS = 32;
    localparam int STMIN = 20;
    localparam int UMMIN = 30;
    localparam int TINIT = 16;
    localparam int CF2CK = 50;
    logic core_clk, reset_n, dev_kick_n, user_init_clock;
    logic start, watch_status, bit_data, bit_valid, bit_ready, busy, done, error;
    logic user_clk_opt_en, user_mode, cfg_bit, cfg_bit_stb;
    psc_init_src_e init_src;
    int n_mismatch, comparisons, seed, n_stb, i;
    logic exp_q[$];
    wire dev_rst_n = reset_n & dev_kick_n;

    psc_link_if link();
    psc_device #(.STATUS_MIN_CYC(STMIN), .CD2UM_MIN_CYC(UMMIN), .T_INIT(TINIT), .BITS(BITS))
    psc_device_inst (.core_clk(core_clk), .reset_n(dev_rst_n), .link(link),
        .user_init_clock(user_init_clock), .init_src(init_src),
        .user_clk_opt_en(user_clk_opt_en), .user_mode(user_mode), .cfg_bit(cfg_bit),
        .cfg_bit_stb(cfg_bit_stb));
    psc_host #(.CF2CK_CYC(CF2CK), .BITS(BITS)) psc_host_inst (.core_clk(core_clk),
        .reset_n(reset_n), .link(link), .start(start), .watch_status(watch_status),
        .bit_data(bit_data), .bit_valid(bit_valid), .bit_ready(bit_ready), .busy(busy),
        .done(done), .error(error));
    psc_checker #(.STATUS_MIN(STMIN), .BITS(BITS), .CF2CK(CF2CK)) psc_checker_inst (
        .core_clk(core_clk), .reset_n(reset_n), .config_req_n(link.config_req_n),
        .config_clock(link.config_clock), .config_data(link.config_data),
        .load_done(link.load_done), .status_n(link.status_n));

    // core clock 50 MHz; user init clock 160 ns with an unrelated phase
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        user_init_clock = 1'b0;
        #7;
        forever #80 user_init_clock = ~user_init_clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expect_v);
        comparisons++;
        if (seen !== expect_v) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expect_v);
        end
    endtask

    task automatic report_and_stop;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bit source: random gaps, holds valid until ready, records each taken bit
    always @(negedge core_clk) begin
        if (bit_ready === 1'b1) begin
            exp_q.push_back(bit_data);
            bit_valid = 1'b0;
        end else if (reset_n && !bit_valid && ($random(seed) & 3) != 0) begin
            bit_data = 1'($random(seed));
            bit_valid = 1'b1;
        end
    end

    // every bit the device takes must be the next one sent, in order
    always @(negedge core_clk) begin
        if (cfg_bit_stb === 1'b1) begin
            n_stb++;
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(32'(cfg_bit), 32'(exp_q.pop_front()));
            end
        end
    end

    task automatic pulse_start(input logic watch, input psc_init_src_e src, input logic opt);
        exp_q.delete();
        n_stb = 0;
        @(negedge core_clk);
        watch_status = watch;
        init_src = src;
        user_clk_opt_en = opt;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
    endtask

    // one whole sequence; hi of zero means user mode must not be reached
    task automatic run_cfg(input logic watch, input psc_init_src_e src, input logic opt,
                           input int lo, input int hi);
        int k;
        int n;
        n = 0;
        pulse_start(watch, src, opt);
        for (k = 0; k < 60 && link.load_done !== 1'b0; k++) begin
            @(negedge core_clk);
        end
        check(32'(k <= 31), 32'h1);
        check(32'(link.status_n), 32'h0);
        check(32'(user_mode), 32'h0);
        for (k = 0; k < 3000 && user_mode !== 1'b1; k++) begin
            @(negedge core_clk);
            if (link.load_done === 1'b1) begin
                n++;
            end
        end
        check(32'(done), 32'h1);
        check(32'(busy), 32'h0);
        check(32'(error), 32'h0);
        check(32'(n_stb), 32'(BITS));
        check(32'(user_mode), 32'(hi != 0));
        if (hi != 0) begin
            check(32'(n >= lo && n <= hi), 32'h1);
        end
    endtask

    // hang guard well beyond the longest expected run
    initial begin
        #(20 * 40000);
        n_mismatch++;
        report_and_stop();
    end

    // main sequence: each init source and wait mode, then a mid-load restart
    initial begin
        seed = 32'h35A37712;
        n_mismatch = 0;
        comparisons = 0;
        n_stb = 0;
        reset_n = 1'b0;
        dev_kick_n = 1'b1;
        start = 1'b0;
        watch_status = 1'b0;
        bit_data = 1'b0;
        bit_valid = 1'b0;
        init_src = PSC_SRC_OSC;
        user_clk_opt_en = 1'b0;
        repeat (16) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        run_cfg(1'b1, PSC_SRC_OSC, 1'b0, UMMIN - 1, UMMIN + 4);
        run_cfg(1'b0, PSC_SRC_CFG, 1'b0, 0, 0);
        run_cfg(1'b1, PSC_SRC_USER, 1'b1, (TINIT - 1) * 8, TINIT * 8 + 16);
        run_cfg(1'b0, PSC_SRC_USER, 1'b0, UMMIN - 1, UMMIN + 4);
        pulse_start(1'b1, PSC_SRC_OSC, 1'b0);
        for (i = 0; i < 3000 && n_stb < 4; i++) begin
            @(negedge core_clk);
        end
        dev_kick_n = 1'b0;
        @(negedge core_clk);
        check(32'(link.status_n), 32'h0);
        dev_kick_n = 1'b1;
        for (i = 0; i < 500 && error !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        check(32'(error), 32'h1);
        check(32'(done), 32'h0);
        // the host restarts by itself; a bit taken just before the error never arrives
        repeat (4) @(negedge core_clk);
        exp_q.delete();
        n_stb = 0;
        for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
            @(negedge core_clk);
        end
        check(32'(done), 32'h1);
        check(32'(n_stb), 32'(BITS));
        run_cfg(1'b1, PSC_SRC_OSC, 1'b0, UMMIN - 1, UMMIN + 4);
        report_and_stop();
    end
endmodule
